// ---- logic/srx_rx_top.sv ----
// receiver cdr lock controller, byte ordering, phase compensation fifo and bit flip
// Function
// RULE1: in lock-to-reference the phase detector is off and serial data unused.
// RULE2: in lock-to-data the phase detector is on and tracks the data.
// RULE3: lock controller offers an automatic and a manual lock mode.
// RULE4: after power-up and each reset the automatic controller sits in lock-to-reference.
// RULE5: automatic mode enters lock-to-data only within ppm threshold, plus signal present in pipe.
// RULE6: outside pipe mode, signal present is ignored by the lock decisions.
// RULE7: recovered clock edges clock the deserialized word into ordering and alignment logic.
// RULE8: byte ordering selectable between aligner-triggered and user-triggered modes.
// RULE9: aligner lock rising edge starts pattern search and reordering if needed.
// RULE10: aligned flag set whenever the pattern is found, pad or not.
// RULE11: another aligner lock rising edge clears aligned and restarts the search.
// RULE12: in user mode a rising edge on the trigger starts search and reordering.
// RULE13: in user mode aligned flag set once pattern found, pad or not.
// RULE14: a phase compensation fifo moves words from recovered clock to fabric clock.
// RULE15: fifo holds four words, latency two to three parallel clock cycles.
// RULE16: channel width through the fifo is 8, 10, 16 or 20 bits.
// RULE17: registered mode adds exactly one parallel clock cycle of latency.
// RULE18: bit flip mirrors bit order inside each byte at fifo output.
// RULE19: manual mode takes the lock state from a fabric control input.
// RULE20: reset clears aligned flag and fifo pointers until first search or write.
//
// The address map and the APB register port were chosen for this implementation.
`default_nettype none
module srx_rx_top (
    input  wire logic        CORE_CLK,            // 20 MHz block clock
    input  wire logic        RESET_N,             // synchronous reset, low active
    input  wire logic        PSEL,                // apb select
    input  wire logic        PENABLE,             // apb access phase
    input  wire logic        PWRITE,              // apb direction
    input  wire logic [7:0]  PADDR,               // apb byte address
    input  wire logic [31:0] PWDATA,              // apb write data
    output logic      [31:0] PRDATA,              // apb read data
    output logic             PREADY,              // apb ready
    output logic             PSLVERR,             // apb error on unmapped address
    input  wire logic        RX_PCLK,             // recovered parallel clock pin
    input  wire logic [19:0] RX_DATA,             // deserialized word pin group
    input  wire logic        RX_SIGNAL_PRESENT,   // signal detect from input buffer
    input  wire logic        WORD_ALIGN_LOCKED,   // lock from the word aligner
    input  wire logic        BYTE_ORDER_TRIGGER,  // fabric ordering request
    input  wire logic        MANUAL_LOCK_TO_DATA, // fabric lock choice in manual mode
    output logic             CDR_PD_EN,           // phase detector enable
    output logic             CDR_LOCK_TO_DATA,    // lock state, high when tracking data
    output logic             BYTE_ORDER_ALIGNED,  // byte order pattern found
    output logic      [19:0] RX_PARALLEL_OUT,     // fabric word
    output logic             RX_OUT_VALID         // one-cycle strobe with the word
);
    // width helpers used by ordering and output
    function automatic logic [19:0] mask_w(input logic [1:0] w, input logic [19:0] d);
        logic [19:0] r;
        case (w)
            srx_pkg::W8:  r = d & 20'h0_00FF;
            srx_pkg::W10: r = d & 20'h0_03FF;
            srx_pkg::W16: r = d & 20'h0_FFFF;
            default:      r = d;
        endcase
        return r;
    endfunction

    function automatic logic [19:0] flip_bytes(input logic [1:0] w, input logic [19:0] d);
        logic [19:0] r;
        r = d;
        if (w == srx_pkg::W8 || w == srx_pkg::W16) begin
            for (int i = 0; i < 8; i++) begin
                r[i]     = d[7-i];
                r[8+i]   = d[15-i];
            end
        end else begin
            for (int i = 0; i < 10; i++) begin
                r[i]     = d[9-i];
                r[10+i]  = d[19-i];
            end
        end
        return r;
    endfunction

    function automatic logic lo_match(input logic [1:0] w, input logic [19:0] d, input logic [9:0] p);
        logic r;
        if (w == srx_pkg::W8 || w == srx_pkg::W16) begin
            r = (d[7:0] == p[7:0]);
        end else begin
            r = (d[9:0] == p);
        end
        return r;
    endfunction

    function automatic logic hi_match(input logic [1:0] w, input logic [19:0] d, input logic [9:0] p);
        logic r;
        case (w)
            srx_pkg::W16: r = (d[15:8] == p[7:0]);
            srx_pkg::W20: r = (d[19:10] == p);
            default:      r = 1'b0;
        endcase
        return r;
    endfunction

    // pin synchronisers; logic reads stage two and later, except the byte order trigger, which is read raw against its stage one
    logic [19:0] data_s1_r, data_s2_r;
    logic [2:0]  pclk_r, wal_r;
    logic [1:0]  sig_r;
    logic        trig_d_r;
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            data_s1_r <= 20'h0_0000;
            data_s2_r <= 20'h0_0000;
            pclk_r    <= 3'h0;
            wal_r     <= 3'h0;
            sig_r     <= 2'h0;
            trig_d_r  <= 1'b0;
        end else begin
            data_s1_r <= RX_DATA;
            data_s2_r <= data_s1_r;
            pclk_r    <= {pclk_r[1:0], RX_PCLK};
            wal_r     <= {wal_r[1:0], WORD_ALIGN_LOCKED};
            sig_r     <= {sig_r[0], RX_SIGNAL_PRESENT};
            trig_d_r  <= BYTE_ORDER_TRIGGER;
        end
    end

    // recovered clock rising edge as a one-cycle enable
    logic pedge, wal_rise, trig_rise, sig_present;
    assign pedge       = pclk_r[1] & ~pclk_r[2]; // [RULE7]
    assign wal_rise    = wal_r[1] & ~wal_r[2];
    assign trig_rise   = BYTE_ORDER_TRIGGER & ~trig_d_r;
    assign sig_present = sig_r[1];

    // apb register file, zero wait states
    srx_pkg::srx_ctrl_t ctrl_r, ctrl_nxt;
    logic [31:0] ppm_r, ppm_nxt, patt_r, patt_nxt, stat;
    logic        apb_wr, addr_ok;
    always_comb begin
        addr_ok  = (PADDR == srx_pkg::CTRL_OFS) || (PADDR == srx_pkg::PPM_OFS) ||
                   (PADDR == srx_pkg::PATT_OFS) || (PADDR == srx_pkg::STAT_OFS);
        apb_wr   = PSEL && PENABLE && PWRITE;
        ctrl_nxt = ctrl_r;
        ppm_nxt  = ppm_r;
        patt_nxt = patt_r;
        if (apb_wr && PADDR == srx_pkg::CTRL_OFS) begin
            ctrl_nxt      = srx_pkg::srx_ctrl_t'(PWDATA);
            ctrl_nxt.rsvd = 24'h00_0000;
        end
        if (apb_wr && PADDR == srx_pkg::PPM_OFS) begin
            ppm_nxt = PWDATA;
        end
        if (apb_wr && PADDR == srx_pkg::PATT_OFS) begin
            patt_nxt = {22'h00_0000, PWDATA[9:0]};
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            ctrl_r <= srx_pkg::srx_ctrl_t'(srx_pkg::CTRL_RST);
            ppm_r  <= srx_pkg::PPM_RST;
            patt_r <= srx_pkg::PATT_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            ppm_r  <= ppm_nxt;
            patt_r <= patt_nxt;
        end
    end

    // read mux; unmapped addresses answer with an error and zero data
    always_comb begin
        case (PADDR)
            srx_pkg::CTRL_OFS: PRDATA = ctrl_r;
            srx_pkg::PPM_OFS:  PRDATA = ppm_r;
            srx_pkg::PATT_OFS: PRDATA = patt_r;
            srx_pkg::STAT_OFS: PRDATA = stat;
            default:           PRDATA = 32'h0000_0000;
        endcase
        PREADY  = 1'b1;
        PSLVERR = PSEL && PENABLE && !addr_ok;
    end

    // ppm check: count recovered edges over a fixed window of core cycles
    logic [srx_pkg::WIN_W-1:0] win_r, win_nxt;
    logic [15:0] edges_r, edges_nxt;
    logic        freq_ok_r, freq_ok_nxt;
    logic [16:0] diff;
    always_comb begin
        win_nxt     = win_r + 11'h001;
        edges_nxt   = pedge ? edges_r + 16'h0001 : edges_r;
        freq_ok_nxt = freq_ok_r;
        diff        = (edges_r >= ppm_r[15:0]) ? {1'b0, edges_r - ppm_r[15:0]} : {1'b0, ppm_r[15:0] - edges_r};
        if (win_r == 11'(srx_pkg::FREQ_WIN_CYC - 1)) begin
            win_nxt     = 11'h000;
            edges_nxt   = 16'h0000;
            freq_ok_nxt = (diff <= {1'b0, ppm_r[31:16]});
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            win_r     <= 11'h000;
            edges_r   <= 16'h0000;
            freq_ok_r <= 1'b0;
        end else begin
            win_r     <= win_nxt;
            edges_r   <= edges_nxt;
            freq_ok_r <= freq_ok_nxt;
        end
    end

    // lock controller
    srx_pkg::srx_lock_t lock_r, lock_nxt;
    logic data_ok;
    always_comb begin
        // signal detect only counts in pipe mode [RULE6]
        data_ok  = freq_ok_r && (!ctrl_r.pipe || sig_present); // [RULE5]
        lock_nxt = lock_r;
        if (!ctrl_r.auto_lock) begin // [RULE3]
            lock_nxt = MANUAL_LOCK_TO_DATA ? srx_pkg::LOCK_DATA : srx_pkg::LOCK_REF; // [RULE19]
        end else begin
            case (lock_r)
                srx_pkg::LOCK_REF:  lock_nxt = data_ok ? srx_pkg::LOCK_DATA : srx_pkg::LOCK_REF;
                srx_pkg::LOCK_DATA: lock_nxt = data_ok ? srx_pkg::LOCK_DATA : srx_pkg::LOCK_REF;
                default:            lock_nxt = srx_pkg::LOCK_REF;
            endcase
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            lock_r <= srx_pkg::LOCK_REF; // [RULE4]
        end else begin
            lock_r <= lock_nxt;
        end
    end
    // phase detector follows the state; reference state ignores data
    assign CDR_PD_EN        = (lock_r == srx_pkg::LOCK_DATA); // [RULE1] [RULE2]
    assign CDR_LOCK_TO_DATA = (lock_r == srx_pkg::LOCK_DATA);

    // byte ordering search and reorder
    srx_pkg::srx_bo_t bo_r, bo_nxt;
    logic        aligned_r, aligned_nxt, swap_r, swap_nxt, bo_start, wide;
    logic [19:0] prev_r, prev_nxt, cur, ordered;
    always_comb begin
        cur         = mask_w(ctrl_r.width, data_s2_r); // [RULE16]
        wide        = (ctrl_r.width == srx_pkg::W16) || (ctrl_r.width == srx_pkg::W20);
        bo_start    = ctrl_r.bo_en && (ctrl_r.bo_user ? trig_rise : wal_rise); // [RULE8] [RULE9] [RULE12]
        prev_nxt    = pedge ? cur : prev_r;
        bo_nxt      = bo_r;
        aligned_nxt = aligned_r;
        swap_nxt    = swap_r;
        if (bo_start) begin
            // a new trigger always drops the old result first
            bo_nxt      = srx_pkg::BO_SEARCH;
            aligned_nxt = 1'b0; // [RULE11]
            swap_nxt    = 1'b0;
        end else begin
            case (bo_r)
                srx_pkg::BO_SEARCH: begin
                    if (pedge && lo_match(ctrl_r.width, cur, patt_r[9:0])) begin
                        bo_nxt      = srx_pkg::BO_IDLE;
                        aligned_nxt = 1'b1; // [RULE10] [RULE13]
                        swap_nxt    = 1'b0;
                    end else if (pedge && wide && hi_match(ctrl_r.width, cur, patt_r[9:0])) begin
                        // pattern in upper byte: shift by one byte, taking the low byte from the previous word
                        bo_nxt      = srx_pkg::BO_IDLE;
                        aligned_nxt = 1'b1; // [RULE10] [RULE13]
                        swap_nxt    = 1'b1;
                    end
                end
                srx_pkg::BO_IDLE: bo_nxt = srx_pkg::BO_IDLE;
                default:          bo_nxt = srx_pkg::BO_IDLE;
            endcase
        end
        ordered = cur;
        if (swap_r && ctrl_r.width == srx_pkg::W16) begin
            ordered = {4'h0, cur[7:0], prev_r[15:8]};
        end else if (swap_r && ctrl_r.width == srx_pkg::W20) begin
            ordered = {cur[9:0], prev_r[19:10]};
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            bo_r      <= srx_pkg::BO_IDLE;
            aligned_r <= 1'b0; // [RULE20]
            swap_r    <= 1'b0;
            prev_r    <= 20'h0_0000;
        end else begin
            bo_r      <= bo_nxt;
            aligned_r <= aligned_nxt;
            swap_r    <= swap_nxt;
            prev_r    <= prev_nxt;
        end
    end
    assign BYTE_ORDER_ALIGNED = aligned_r;

    // phase compensation fifo; reads start once two words wait, giving two parallel cycles
    logic [19:0] mem_r [srx_pkg::FIFO_DEPTH];
    logic [19:0] mem_nxt [srx_pkg::FIFO_DEPTH];
    logic [srx_pkg::PTR_W-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt, count;
    logic [19:0] stage_r, stage_nxt, rd_word;
    srx_pkg::srx_word_t out_r, out_nxt;
    logic wr, rd, full;
    always_comb begin
        count     = wptr_r - rptr_r;
        full      = (count == 3'(srx_pkg::FIFO_DEPTH)); // [RULE15]
        wr        = pedge && !ctrl_r.reg_mode && !full; // [RULE14]
        rd        = pedge && !ctrl_r.reg_mode && (count >= srx_pkg::FIFO_LAT_CNT);
        mem_nxt   = mem_r;
        wptr_nxt  = wptr_r;
        rptr_nxt  = rptr_r;
        stage_nxt = pedge ? ordered : stage_r;
        rd_word   = mem_r[rptr_r[1:0]];
        out_nxt   = out_r;
        out_nxt.valid = 1'b0;
        if (wr) begin
            mem_nxt[wptr_r[1:0]] = ordered;
            wptr_nxt             = wptr_r + 3'h1;
        end
        if (rd) begin
            rptr_nxt     = rptr_r + 3'h1;
            out_nxt.data = ctrl_r.bitflip ? flip_bytes(ctrl_r.width, rd_word) : rd_word; // [RULE18]
            out_nxt.valid = 1'b1;
        end
        if (ctrl_r.reg_mode) begin
            // fifo bypassed: one register stage, flushed pointers
            rptr_nxt = wptr_r;
            if (pedge) begin
                out_nxt.data  = ctrl_r.bitflip ? flip_bytes(ctrl_r.width, stage_r) : stage_r; // [RULE17] [RULE18]
                out_nxt.valid = 1'b1;
            end
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            for (int i = 0; i < srx_pkg::FIFO_DEPTH; i++) begin
                mem_r[i] <= 20'h0_0000;
            end
            wptr_r  <= 3'h0; // [RULE20]
            rptr_r  <= 3'h0;
            stage_r <= 20'h0_0000;
            out_r   <= '0;
        end else begin
            mem_r   <= mem_nxt;
            wptr_r  <= wptr_nxt;
            rptr_r  <= rptr_nxt;
            stage_r <= stage_nxt;
            out_r   <= out_nxt;
        end
    end
    assign RX_PARALLEL_OUT = out_r.data;
    assign RX_OUT_VALID    = out_r.valid;

    // status word
    always_comb begin
        stat = 32'h0000_0000;
        stat[srx_pkg::STAT_LOCK_BIT]   = CDR_LOCK_TO_DATA;
        stat[srx_pkg::STAT_ALIGN_BIT]  = aligned_r;
        stat[srx_pkg::STAT_FREQ_BIT]   = freq_ok_r;
        stat[srx_pkg::STAT_SEARCH_BIT] = (bo_r == srx_pkg::BO_SEARCH);
        stat[srx_pkg::STAT_CNT_LSB +: srx_pkg::PTR_W] = count;
    end

    // checks next to the logic
    property p_ref_pd_off;
        @(posedge CORE_CLK) disable iff (!RESET_N) (lock_r == srx_pkg::LOCK_REF) |-> !CDR_PD_EN;
    endproperty
    a_ref_pd_off: assert property (p_ref_pd_off) else $error("pd on in reference state"); // [RULE1]
    property p_data_pd_on;
        @(posedge CORE_CLK) disable iff (!RESET_N) CDR_LOCK_TO_DATA |-> CDR_PD_EN;
    endproperty
    a_data_pd_on: assert property (p_data_pd_on) else $error("pd off in data state"); // [RULE2]
    property p_reset_ref;
        @(posedge CORE_CLK) $rose(RESET_N) |-> !CDR_LOCK_TO_DATA && !BYTE_ORDER_ALIGNED && count == 3'h0;
    endproperty
    a_reset_ref: assert property (p_reset_ref) else $error("state not cleared by reset"); // [RULE4]
    property p_auto_enter;
        @(posedge CORE_CLK) disable iff (!RESET_N)
            $rose(CDR_LOCK_TO_DATA) && $past(ctrl_r.auto_lock) |->
            $past(freq_ok_r) && (!$past(ctrl_r.pipe) || $past(sig_present));
    endproperty
    a_auto_enter: assert property (p_auto_enter) else $error("data lock without conditions"); // [RULE5]
    property p_manual;
        @(posedge CORE_CLK) disable iff (!RESET_N)
            !ctrl_r.auto_lock |=> CDR_LOCK_TO_DATA == $past(MANUAL_LOCK_TO_DATA);
    endproperty
    a_manual: assert property (p_manual) else $error("manual lock not followed"); // [RULE19]
    property p_restart;
        @(posedge CORE_CLK) disable iff (!RESET_N) bo_start |=> !BYTE_ORDER_ALIGNED && bo_r == srx_pkg::BO_SEARCH;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not clear aligned"); // [RULE11]
    property p_found;
        @(posedge CORE_CLK) disable iff (!RESET_N)
            bo_r == srx_pkg::BO_SEARCH && !bo_start && pedge && lo_match(ctrl_r.width, cur, patt_r[9:0])
            |=> BYTE_ORDER_ALIGNED [*2];
    endproperty
    a_found: assert property (p_found) else $error("pattern found but not aligned"); // [RULE10]
    property p_fifo_lat;
        @(posedge CORE_CLK) disable iff (!RESET_N) rd |-> count >= 3'h2 && count <= 3'h3;
    endproperty
    a_fifo_lat: assert property (p_fifo_lat) else $error("fifo read outside latency window"); // [RULE15]
    property p_reg_lat;
        @(posedge CORE_CLK) disable iff (!RESET_N)
            ctrl_r.reg_mode && $past(ctrl_r.reg_mode) && pedge && !ctrl_r.bitflip
            |=> RX_OUT_VALID && RX_PARALLEL_OUT == $past(stage_r);
    endproperty
    a_reg_lat: assert property (p_reg_lat) else $error("registered mode latency wrong"); // [RULE17]
    c_lock_data: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) $rose(CDR_LOCK_TO_DATA));
    c_swap: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) $rose(swap_r));
    c_out: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) RX_OUT_VALID && ctrl_r.bitflip);
endmodule
`default_nettype wire

// ---- logic/srx_pkg.sv ----
// package of constants and types for the receiver lock, byte order and fifo block
`default_nettype none
package srx_pkg;
    // apb register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PPM_OFS  = 8'h04;
    localparam logic [7:0] PATT_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0C;
    // values after reset
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] PPM_RST  = 32'h0001_0080;
    localparam logic [31:0] PATT_RST = 32'h0000_00BC;
    // status field positions
    localparam int STAT_LOCK_BIT   = 0;
    localparam int STAT_ALIGN_BIT  = 1;
    localparam int STAT_FREQ_BIT   = 2;
    localparam int STAT_SEARCH_BIT = 3;
    localparam int STAT_CNT_LSB    = 4;
    // datapath and fifo shape
    localparam int DW         = 20;
    localparam int FIFO_DEPTH = 4;
    localparam int PTR_W      = 3;
    localparam logic [PTR_W-1:0] FIFO_LAT_CNT = 3'h2;
    // channel width encodings
    localparam logic [1:0] W8  = 2'h0;
    localparam logic [1:0] W10 = 2'h1;
    localparam logic [1:0] W16 = 2'h2;
    localparam logic [1:0] W20 = 2'h3;
    // frequency check window
    localparam int CLK_PERIOD_NS = 50;
    localparam int FREQ_WIN_NS   = 51200;
    localparam int FREQ_WIN_CYC  = FREQ_WIN_NS / CLK_PERIOD_NS;
    localparam int WIN_W         = 11;
    // control register layout, bit 0 at the bottom
    typedef struct packed {
        logic [23:0] rsvd;
        logic        bo_en;
        logic [1:0]  width;
        logic        reg_mode;
        logic        bitflip;
        logic        bo_user;
        logic        pipe;
        logic        auto_lock;
    } srx_ctrl_t;
    // parallel word with its strobe
    typedef struct packed {
        logic          valid;
        logic [DW-1:0] data;
    } srx_word_t;
    typedef enum logic {LOCK_REF, LOCK_DATA} srx_lock_t;
    typedef enum logic {BO_IDLE, BO_SEARCH} srx_bo_t;
endpackage
`default_nettype wire

// ---- verification/srx_tx_model.sv ----
// remote transmitter model: recovered parallel clock and deserialized words
`default_nettype none
module srx_tx_model (
    input  wire logic [19:0] word, // word sent on every parallel clock
    output var  logic        pclk, // parallel clock, 400 ns period
    output var  logic [19:0] data  // word group, changes on falling edge
);
    timeunit 1ns;
    timeprecision 1ps;
    // free running: the recovered clock runs while the channel is up
    initial begin
        pclk = 1'b0;
        forever #200 pclk = ~pclk;
    end
    // falling edge launch keeps the word steady around every rise; unknown until the first falling edge at 400 ns
    always @(negedge pclk) data <= word;
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the receiver lock, byte order and fifo block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // width, flip and registered mode cases: control, word sent, expected, mask
    // the last aligner search leaves the byte swap on, so 16 and 20 bit words are sent pre-swapped
    localparam logic [31:0] T_CTRL [4] = '{32'h0000_0049, 32'h0000_0059, 32'h0000_0001, 32'h0000_0061};
    localparam logic [19:0] T_WORD [4] = '{20'h0_ADBC, 20'h0_ADBC, 20'h0_00A5, 20'h3_7AAF};
    localparam logic [19:0] T_EXP  [4] = '{20'h0_3DB5, 20'h0_3DB5, 20'h0_00A5, 20'hA_BCDE};
    localparam logic [19:0] T_MASK [4] = '{20'h0_FFFF, 20'h0_FFFF, 20'h0_00FF, 20'hF_FFFF};
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        sig = 1'b0, wal = 1'b0, trig = 1'b0, man = 1'b0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [19:0] word = 20'h0_ADBC, pdata, rx_out;
    logic        pclk, pready, pslverr, pd_en, lock, aligned, valid;
    int          n_mismatch = 0, samples_checked = 0;

    always #25 clk = ~clk;

    srx_tx_model i_tx (.word(word), .pclk(pclk), .data(pdata));
    srx_rx_top i_dut (.CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RX_PCLK(pclk),
        .RX_DATA(pdata), .RX_SIGNAL_PRESENT(sig), .WORD_ALIGN_LOCKED(wal), .BYTE_ORDER_TRIGGER(trig),
        .MANUAL_LOCK_TO_DATA(man), .CDR_PD_EN(pd_en), .CDR_LOCK_TO_DATA(lock), .BYTE_ORDER_ALIGNED(aligned),
        .RX_PARALLEL_OUT(rx_out), .RX_OUT_VALID(valid));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    // bounded wait on lock (0), aligned (1) or valid (2)
    task automatic wait_on(input int k, input logic v, input int lim);
        int n = 0;
        while ((k == 0 ? lock : k == 1 ? aligned : valid) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        if ((k == 0 ? lock : k == 1 ? aligned : valid) !== v) begin
            n_mismatch++;
            $display("MISMATCH t=%0t wait on %0d timed out", $time, k);
            give_verdict;
        end
    endtask

    // skip past c output strobes, so old fifo words are flushed
    task automatic nvalid(input int c);
        repeat (c) begin
            @(posedge clk);
            wait_on(2, 1'b1, 40);
        end
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH t=%0t apb ready timed out", $time);
            give_verdict;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        chk(lock, 1'b0, "lock after reset");
        chk(aligned, 1'b0, "aligned after reset");
        apb(1'b0, srx_pkg::CTRL_OFS, 32'h0000_0000);
        chk(rd, srx_pkg::CTRL_RST, "ctrl reset");
        apb(1'b0, srx_pkg::PPM_OFS, 32'h0000_0000);
        chk(rd, srx_pkg::PPM_RST, "ppm reset");
        apb(1'b0, srx_pkg::PATT_OFS, 32'h0000_0000);
        chk(rd, srx_pkg::PATT_RST, "pattern reset");
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001, "unmapped read");
        $display("test reset done");
        // signal absent outside pipe mode must not hold back the lock
        wait_on(0, 1'b1, 2600);
        chk(pd_en, 1'b1, "detector on");
        apb(1'b1, srx_pkg::CTRL_OFS, 32'h0000_0003);
        wait_on(0, 1'b0, 2600);
        sig <= 1'b1;
        wait_on(0, 1'b1, 2600);
        $display("test auto lock done");
        apb(1'b1, srx_pkg::CTRL_OFS, 32'h0000_0000);
        wait_on(0, 1'b0, 4);
        chk(pd_en, 1'b0, "detector off");
        man <= 1'b1;
        wait_on(0, 1'b1, 4);
        // status: lock to data, frequency good, two words waiting in the fifo
        apb(1'b0, srx_pkg::STAT_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0025, "status word");
        $display("test manual lock done");
        apb(1'b1, srx_pkg::CTRL_OFS, 32'h0000_00C5);
        trig <= 1'b1;
        wait_on(1, 1'b1, 200);
        nvalid(4);
        chk(rx_out & 20'h0_FFFF, 20'h0_ADBC, "user order");
        trig <= 1'b0;
        word <= 20'h0_BCAD;
        apb(1'b1, srx_pkg::CTRL_OFS, 32'h0000_00C1);
        repeat (16) @(posedge clk);
        wal <= 1'b1;
        wait_on(1, 1'b0, 20);
        wait_on(1, 1'b1, 200);
        nvalid(4);
        chk(rx_out & 20'h0_FFFF, 20'h0_ADBC, "swapped order");
        wal <= 1'b0;
        repeat (4) @(posedge clk);
        wal <= 1'b1;
        wait_on(1, 1'b0, 20);
        wait_on(1, 1'b1, 200);
        $display("test byte order done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, srx_pkg::CTRL_OFS, T_CTRL[i]);
            word <= T_WORD[i];
            nvalid(5);
            chk(rx_out & T_MASK[i], T_EXP[i], "width case");
        end
        $display("test widths done");
        give_verdict;
    end
endmodule
`default_nettype wire
